/* File: core/bpabc_port.sv */
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module bpabc_port
  import bpabc_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  input wire logic [BPABC_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic QUAD_BUS_CLOCK_IN,
  input wire logic [5:0] FIRST_PORT_PIN_IN,
  output logic [5:0] FIRST_PORT_PIN_OUT,
  output logic [5:0] FIRST_PORT_PIN_OE_N_OUT,
  output logic [5:0] FIRST_PORT_PULLUP_OUT,
  input wire logic [7:0] SECOND_PORT_PIN_IN,
  output logic [7:0] SECOND_PORT_PIN_OUT,
  output logic [7:0] SECOND_PORT_PIN_OE_N_OUT,
  output logic [7:0] SECOND_PORT_PULLUP_OUT,
  input wire logic [3:0] THIRD_PORT_PIN_IN,
  output logic [2:0] THIRD_PORT_PIN_OUT,
  output logic [2:0] THIRD_PORT_PIN_OE_N_OUT,
  output logic CLK_PIN_ACTIVE_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [5:0] first_port_data_reg;
  logic [7:0] second_port_data_reg;
  logic [2:0] third_port_data_reg;
  logic [5:0] first_port_direction_reg;
  logic [7:0] second_port_direction_reg;
  logic [2:0] third_port_direction_reg;
  logic [5:0] first_port_pullup_enable_reg;
  logic osc_pin_clock_out_select_reg;
  logic [7:0] second_port_pullup_enable_reg;
  logic [2:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic [5:0] a_oe_n_reg;
  logic [5:0] a_out_reg;
  logic [5:0] a_pu_reg;
  logic [7:0] b_oe_n_reg;
  logic [7:0] b_out_reg;
  logic [7:0] b_pu_reg;
  logic [2:0] c_oe_n_reg;
  logic [2:0] c_out_reg;
  logic clk_act_reg;
  logic [5:0] a_sync;
  logic [7:0] b_sync;
  logic [3:0] c_sync;
  logic [3:0] idx;
  logic wr_go;
  logic rd_go;
  logic clk_out_on;
  logic irq_on;
  logic [5:0] a_drive;
  logic [7:0] rd_next;
  logic b_written_reg = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] mux_rd(input logic [7:0] dir, input logic [7:0] lat,
                                        input logic [7:0] pin);
    mux_rd = (dir & lat) | (~dir & pin);
  endfunction : mux_rd

  function automatic logic [7:0] pu_on(input logic [7:0] pue, input logic [7:0] dir);
    pu_on = pue & ~dir;
  endfunction : pu_on

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  bpabc_sync #(.W(6)) u_sync_a (
    .clk_in(CLK_SYS_IN),
    .d_in(FIRST_PORT_PIN_IN),
    .q_out(a_sync)
  );
  bpabc_sync #(.W(8)) u_sync_b (
    .clk_in(CLK_SYS_IN),
    .d_in(SECOND_PORT_PIN_IN),
    .q_out(b_sync)
  );
  bpabc_sync #(.W(4)) u_sync_c (
    .clk_in(CLK_SYS_IN),
    .d_in(THIRD_PORT_PIN_IN),
    .q_out(c_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; one wait cycle per access
  assign idx = AVS_ADDRESS_IN[BPABC_ADDR_W-1:2];
  assign wr_go = AVS_WRITE_IN && !ack_reg && AVS_BYTEENABLE_IN[0];
  assign rd_go = AVS_READ_IN && !ack_reg;
  assign irq_on = ctrl_reg[BPABC_CTRL_IRQ_BIT];
  assign clk_out_on = osc_pin_clock_out_select_reg &&
    ((ctrl_reg[BPABC_CTRL_OPT_LSB +: 2] == BPABC_OPT_INTERNAL) ||
     (ctrl_reg[BPABC_CTRL_OPT_LSB +: 2] == BPABC_OPT_RC));

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data latches, never reset
  always_ff @(posedge CLK_SYS_IN) begin
    if (wr_go && idx == BPABC_IDX_A_DATA) begin
      first_port_data_reg <= AVS_WRITEDATA_IN[5:0];
    end
    if (wr_go && idx == BPABC_IDX_B_DATA) begin
      second_port_data_reg <= AVS_WRITEDATA_IN[7:0];
    end
    if (wr_go && idx == BPABC_IDX_C_DATA) begin
      third_port_data_reg <= AVS_WRITEDATA_IN[2:0];
    end
  end

  // Marks the port B latch as loaded
  always_ff @(posedge CLK_SYS_IN) begin
    if (wr_go && idx == BPABC_IDX_B_DATA) begin
      b_written_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction, pull-up and control registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      first_port_direction_reg <= BPABC_A_DIR_RST;
      second_port_direction_reg <= BPABC_B_DIR_RST;
      third_port_direction_reg <= BPABC_C_DIR_RST;
      first_port_pullup_enable_reg <= BPABC_PUE_RST[5:0];
      osc_pin_clock_out_select_reg <= 1'b0;
      second_port_pullup_enable_reg <= BPABC_PUE_RST;
      ctrl_reg <= BPABC_CTRL_RST;
    end else if (wr_go) begin
      case (idx)
        BPABC_IDX_A_DIR: first_port_direction_reg <= AVS_WRITEDATA_IN[5:0];
        BPABC_IDX_B_DIR: second_port_direction_reg <= AVS_WRITEDATA_IN[7:0];
        BPABC_IDX_C_DIR: third_port_direction_reg <= AVS_WRITEDATA_IN[2:0];
        BPABC_IDX_A_PUE: begin
          first_port_pullup_enable_reg <= AVS_WRITEDATA_IN[5:0];
          osc_pin_clock_out_select_reg <= AVS_WRITEDATA_IN[BPABC_OSC_SEL_BIT];
        end
        BPABC_IDX_B_PUE: second_port_pullup_enable_reg <= AVS_WRITEDATA_IN[7:0];
        BPABC_IDX_CTRL: ctrl_reg <= AVS_WRITEDATA_IN[2:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rd_next = 8'h00;
    case (idx)
      BPABC_IDX_A_DATA: begin
        rd_next = mux_rd({2'b00, first_port_direction_reg},
          {2'b00, first_port_data_reg}, {2'b00, a_sync});
        rd_next[BPABC_A_INONLY_BIT] = irq_on ? 1'b0 : a_sync[BPABC_A_INONLY_BIT];
      end
      BPABC_IDX_B_DATA: rd_next = mux_rd(second_port_direction_reg, second_port_data_reg,
        b_sync);
      BPABC_IDX_C_DATA: begin
        rd_next = mux_rd({5'h00, third_port_direction_reg}, {5'h00, third_port_data_reg},
          {4'h0, c_sync});
        rd_next[BPABC_C_INONLY_BIT] = c_sync[BPABC_C_INONLY_BIT];
      end
      BPABC_IDX_A_DIR: rd_next = {2'b00, first_port_direction_reg};
      BPABC_IDX_B_DIR: rd_next = second_port_direction_reg;
      BPABC_IDX_C_DIR: rd_next = {5'h00, third_port_direction_reg};
      BPABC_IDX_A_PUE: rd_next = {osc_pin_clock_out_select_reg, 1'b0,
        first_port_pullup_enable_reg};
      BPABC_IDX_B_PUE: rd_next = second_port_pullup_enable_reg;
      BPABC_IDX_CTRL: rd_next = {5'h00, ctrl_reg};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_reg <= {24'h00_0000, rd_next};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers and pull-ups
  always_comb begin
    a_drive = first_port_direction_reg;
    a_drive[BPABC_A_INONLY_BIT] = 1'b0;
    if (clk_out_on) begin
      a_drive[BPABC_A_OSC_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      a_oe_n_reg <= 6'h3f;
      a_out_reg <= 6'h00;
      a_pu_reg <= 6'h00;
      b_oe_n_reg <= 8'hff;
      b_out_reg <= 8'h00;
      b_pu_reg <= 8'h00;
      c_oe_n_reg <= 3'h7;
      c_out_reg <= 3'h0;
      clk_act_reg <= 1'b0;
    end else begin
      a_oe_n_reg <= ~a_drive;
      a_out_reg <= first_port_data_reg;
      a_pu_reg <= 6'(pu_on({2'b00, first_port_pullup_enable_reg},
        {2'b00, a_drive}));
      if (clk_out_on) begin
        a_pu_reg[BPABC_A_OSC_BIT] <= 1'b0;
      end
      b_oe_n_reg <= ~second_port_direction_reg;
      b_out_reg <= second_port_data_reg;
      b_pu_reg <= pu_on(second_port_pullup_enable_reg, second_port_direction_reg);
      c_oe_n_reg <= ~third_port_direction_reg;
      c_out_reg <= third_port_data_reg;
      clk_act_reg <= clk_out_on;
    end
  end

  assign AVS_READDATA_OUT = rdata_reg;
  assign AVS_WAITREQUEST_OUT = !ack_reg;
  assign FIRST_PORT_PIN_OE_N_OUT = a_oe_n_reg;
  assign FIRST_PORT_PULLUP_OUT = a_pu_reg;
  assign SECOND_PORT_PIN_OUT = b_out_reg;
  assign SECOND_PORT_PIN_OE_N_OUT = b_oe_n_reg;
  assign SECOND_PORT_PULLUP_OUT = b_pu_reg;
  assign THIRD_PORT_PIN_OUT = c_out_reg;
  assign THIRD_PORT_PIN_OE_N_OUT = c_oe_n_reg;
  assign CLK_PIN_ACTIVE_OUT = clk_act_reg;

  // Clock pass-through on the oscillator pin is a mux of the clock itself
  always_comb begin
    FIRST_PORT_PIN_OUT = a_out_reg;
    if (clk_act_reg) begin
      FIRST_PORT_PIN_OUT[BPABC_A_OSC_BIT] = QUAD_BUS_CLOCK_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_dir_reset_a: assert property (@(posedge CLK_SYS_IN) SRST_IN |=>
    first_port_direction_reg == 6'h00) else $error("port A direction not cleared");
  a_dir_reset_b: assert property (@(posedge CLK_SYS_IN) SRST_IN |=>
    second_port_direction_reg == 8'h00) else $error("port B direction not cleared");
  a_dir_reset_c: assert property (@(posedge CLK_SYS_IN) SRST_IN |=>
    third_port_direction_reg == 3'h0) else $error("port C direction not cleared");
  a_drive_b_dir: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    ##1 (SECOND_PORT_PIN_OE_N_OUT == ~$past(second_port_direction_reg)))
    else $error("port B enable does not follow direction");
  a_bit_two_in: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    FIRST_PORT_PIN_OE_N_OUT[2]) else $error("port A bit two driven");
  a_pullup_dir: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (SECOND_PORT_PULLUP_OUT & ~SECOND_PORT_PIN_OE_N_OUT) == 8'h00)
    else $error("pull-up on while driving");
  a_b_read_mux: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    rd_go && idx == BPABC_IDX_B_DATA |=> !AVS_WAITREQUEST_OUT &&
    AVS_READDATA_OUT[7:0] == $past(mux_rd(second_port_direction_reg,
    second_port_data_reg, b_sync))) else $error("port B read wrong");
  a_irq_read_zero: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    rd_go && idx == BPABC_IDX_A_DATA && irq_on |=> AVS_READDATA_OUT[2] == 1'b0)
    else $error("bit two not zero under interrupt");
  a_clk_opt_xtal: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    ctrl_reg[2:1] == BPABC_OPT_XTAL |=> !CLK_PIN_ACTIVE_OUT)
    else $error("clock out under crystal option");
  a_latch_keep: assert property (@(posedge CLK_SYS_IN)
    SRST_IN && b_written_reg |=> $stable(second_port_data_reg))
    else $error("reset changed latch");
  a_drive_a_dir: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    ##1 ((FIRST_PORT_PIN_OE_N_OUT | 6'h14) == (~$past(first_port_direction_reg) | 6'h14)))
    else $error("port A enable does not follow direction");
  a_drive_c_dir: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    ##1 (THIRD_PORT_PIN_OE_N_OUT == ~$past(third_port_direction_reg)))
    else $error("port C enable does not follow direction");
  a_pullup_a_out: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (FIRST_PORT_PULLUP_OUT & ~FIRST_PORT_PIN_OE_N_OUT) == 6'h00)
    else $error("port A pull-up on while driving");
  a_pue_off_a: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    ##1 ((FIRST_PORT_PULLUP_OUT & ~$past(first_port_pullup_enable_reg)) == 6'h00))
    else $error("port A pull-up on while disabled");
  a_pue_off_b: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    ##1 ((SECOND_PORT_PULLUP_OUT & ~$past(second_port_pullup_enable_reg)) == 8'h00))
    else $error("port B pull-up on while disabled");
  a_osc_pin_drive: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    CLK_PIN_ACTIVE_OUT |-> !FIRST_PORT_PIN_OE_N_OUT[BPABC_A_OSC_BIT] &&
    !FIRST_PORT_PULLUP_OUT[BPABC_A_OSC_BIT]) else $error("clock pin not driven");
  a_wait_one: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("request not answered");
  a_wait_short: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT) else $error("answer held too long");
  a_c_read_pin: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    rd_go && idx == BPABC_IDX_C_DATA |=> AVS_READDATA_OUT[BPABC_C_INONLY_BIT] ==
    $past(c_sync[BPABC_C_INONLY_BIT])) else $error("port C bit three not pin");
  a_latch_write: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    wr_go && idx == BPABC_IDX_B_DATA |=> second_port_data_reg ==
    $past(AVS_WRITEDATA_IN[7:0])) else $error("port B latch not written");
  a_sync_delay: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    ##2 (b_sync == $past(SECOND_PORT_PIN_IN, 2))) else $error("synchroniser delay wrong");
  a_pue_b_read: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    rd_go && idx == BPABC_IDX_B_PUE |=> AVS_READDATA_OUT[7:0] ==
    $past(second_port_pullup_enable_reg)) else $error("port B pull-up read wrong");
  c_b_read: cover property (@(posedge CLK_SYS_IN) rd_go && idx == BPABC_IDX_B_DATA);
  c_clk_out: cover property (@(posedge CLK_SYS_IN) CLK_PIN_ACTIVE_OUT);
  c_c_write: cover property (@(posedge CLK_SYS_IN) wr_go && idx == BPABC_IDX_C_DATA);
  c_irq_read: cover property (@(posedge CLK_SYS_IN) rd_go && idx == BPABC_IDX_A_DATA && irq_on);
  c_mid_reset: cover property (@(posedge CLK_SYS_IN) SRST_IN && b_written_reg);
endmodule : bpabc_port
`default_nettype wire

/* File: core/bpabc_pkg.sv */
package bpabc_pkg;
  // Register word indices (byte address = index * 4)
  localparam logic [3:0] BPABC_IDX_A_DATA = 4'h0;
  localparam logic [3:0] BPABC_IDX_B_DATA = 4'h1;
  localparam logic [3:0] BPABC_IDX_C_DATA = 4'h2;
  localparam logic [3:0] BPABC_IDX_A_DIR = 4'h4;
  localparam logic [3:0] BPABC_IDX_B_DIR = 4'h5;
  localparam logic [3:0] BPABC_IDX_C_DIR = 4'h6;
  localparam logic [3:0] BPABC_IDX_A_PUE = 4'h8;
  localparam logic [3:0] BPABC_IDX_B_PUE = 4'h9;
  localparam logic [3:0] BPABC_IDX_CTRL = 4'hc;
  localparam int BPABC_ADDR_W = 6;
  // Field positions
  localparam int BPABC_A_INONLY_BIT = 2;
  localparam int BPABC_A_OSC_BIT = 4;
  localparam int BPABC_OSC_SEL_BIT = 7;
  localparam int BPABC_C_INONLY_BIT = 3;
  localparam int BPABC_CTRL_IRQ_BIT = 0;
  localparam int BPABC_CTRL_OPT_LSB = 1;
  // Reset values
  localparam logic [5:0] BPABC_A_DIR_RST = 6'h00;
  localparam logic [7:0] BPABC_B_DIR_RST = 8'h00;
  localparam logic [2:0] BPABC_C_DIR_RST = 3'h0;
  localparam logic [7:0] BPABC_PUE_RST = 8'h00;
  localparam logic [2:0] BPABC_CTRL_RST = 3'h0;
  // Clock source options
  typedef enum logic [1:0] {
    BPABC_OPT_INTERNAL = 2'b00,
    BPABC_OPT_EXTCLK = 2'b01,
    BPABC_OPT_RC = 2'b10,
    BPABC_OPT_XTAL = 2'b11
  } bpabc_osc_opt_t;
endpackage : bpabc_pkg

/* File: core/bpabc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module bpabc_sync
  import bpabc_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  // Two-stage pin synchroniser
  always_ff @(posedge clk_in) begin
    meta_reg <= d_in;
    q_reg <= meta_reg;
  end
  assign q_out = q_reg;
endmodule : bpabc_sync
`default_nettype wire

/* File: testbench/bpabc_board.sv */
`timescale 1ns/10ps
`default_nettype none
module bpabc_board (
  input wire logic clk_in,
  input wire logic [17:0] out_in,
  input wire logic [17:0] oe_n_in,
  input wire logic [17:0] pu_in,
  input wire logic [17:0] ext_in,
  input wire logic [17:0] ext_en_in,
  output logic [17:0] pin_out
);
  logic [17:0] wander_reg = 18'h2aaaa;
  //////////////////////////////////////////////////////////////////////
  // Floating pins wander every cycle
  always_ff @(posedge clk_in) begin
    wander_reg <= ~wander_reg;
  end
  //////////////////////////////////////////////////////////////////////
  // Pin level: device driver, board driver, pull-up, float
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      if (!oe_n_in[i]) pin_out[i] = out_in[i];
      else if (ext_en_in[i]) pin_out[i] = ext_in[i];
      else if (pu_in[i]) pin_out[i] = 1'b1;
      else pin_out[i] = wander_reg[i];
    end
  end
endmodule : bpabc_board
`default_nettype wire

/* File: testbench/bidir_port_abc_pins_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module bidir_port_abc_pins_tb_top;
  import bpabc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic avs_rd = 1'b0;
  logic avs_wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h1;
  logic [31:0] rdata, rd_cap;
  logic waitreq, quad = 1'b0, clk_act;
  logic [17:0] ext = 18'h0, ext_en = 18'h3ffff, pins;
  logic [5:0] a_out, a_oe_n, a_pu;
  logic [7:0] b_out, b_oe_n, b_pu;
  logic [2:0] c_out, c_oe_n;
  int error_cnt = 0;
  int tests_run = 0;
  //////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) quad <= ~quad;
  bpabc_port dut (.CLK_SYS_IN(clk), .SRST_IN(srst), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(avs_rd), .AVS_WRITE_IN(avs_wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
    .QUAD_BUS_CLOCK_IN(quad), .FIRST_PORT_PIN_IN(pins[5:0]), .FIRST_PORT_PIN_OUT(a_out),
    .FIRST_PORT_PIN_OE_N_OUT(a_oe_n), .FIRST_PORT_PULLUP_OUT(a_pu),
    .SECOND_PORT_PIN_IN(pins[13:6]), .SECOND_PORT_PIN_OUT(b_out),
    .SECOND_PORT_PIN_OE_N_OUT(b_oe_n), .SECOND_PORT_PULLUP_OUT(b_pu),
    .THIRD_PORT_PIN_IN(pins[17:14]), .THIRD_PORT_PIN_OUT(c_out),
    .THIRD_PORT_PIN_OE_N_OUT(c_oe_n), .CLK_PIN_ACTIVE_OUT(clk_act));
  bpabc_board board (.clk_in(clk), .out_in({1'b0, c_out, b_out, a_out}),
    .oe_n_in({1'b1, c_oe_n, b_oe_n, a_oe_n}), .pu_in({4'h0, b_pu, a_pu}),
    .ext_in(ext), .ext_en_in(ext_en), .pin_out(pins));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] ad(input logic [3:0] i);
    return {i, 2'b00};
  endfunction : ad
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    avs_wr <= w;
    avs_rd <= ~w;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    rd_cap = rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [3:0] i, input logic [7:0] d);
    bus(1'b1, ad(i), d);
  endtask : put
  task automatic expect_rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd_cap, {24'h0, e});
  endtask : expect_rd
  task automatic set_ext(input logic [17:0] v);
    @(posedge clk);
    ext <= v;
    repeat (4) @(negedge clk);
  endtask : set_ext
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(32'(a_oe_n), 32'h3f);
    chk(32'(b_oe_n), 32'hff);
    chk(32'(c_oe_n), 32'h7);
    chk(32'({a_pu, b_pu}), 32'h0);
    expect_rd(ad(BPABC_IDX_A_DIR), 8'h00);
    expect_rd(ad(BPABC_IDX_B_DIR), 8'h00);
    expect_rd(ad(BPABC_IDX_C_DIR), 8'h00);
  endtask : t_reset
  task automatic t_port_b;
    set_ext({4'h0, 8'h3c, 6'h00});
    put(BPABC_IDX_B_DATA, 8'ha5);
    expect_rd(ad(BPABC_IDX_B_DATA), 8'h3c);
    put(BPABC_IDX_B_DIR, 8'h0f);
    chk(32'(b_oe_n), 32'hf0);
    expect_rd(ad(BPABC_IDX_B_DATA), 8'h35);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    put(BPABC_IDX_B_DIR, 8'hff);
    chk(32'(b_out), 32'ha5);
    expect_rd(ad(BPABC_IDX_B_DATA), 8'ha5);
  endtask : t_port_b
  task automatic t_pullup;
    put(BPABC_IDX_B_PUE, 8'hff);
    chk(32'(b_pu), 32'h00);
    put(BPABC_IDX_B_DIR, 8'h0f);
    for (int i = 0; i < 8; i++) begin
      put(BPABC_IDX_B_PUE, 8'h01 << i);
      chk(32'(b_pu), 32'((8'h01 << i) & 8'hf0));
      expect_rd(ad(BPABC_IDX_B_PUE), 8'h01 << i);
    end
    put(BPABC_IDX_B_PUE, 8'h00);
    chk(32'(b_pu), 32'h00);
  endtask : t_pullup
  task automatic t_port_a;
    set_ext(18'h0);
    put(BPABC_IDX_A_DATA, 8'h15);
    put(BPABC_IDX_A_DIR, 8'h3f);
    chk(32'(a_oe_n), 32'h04);
    chk(32'(a_out), 32'h15);
    expect_rd(ad(BPABC_IDX_A_DATA), 8'h11);
    put(BPABC_IDX_A_DIR, 8'h00);
    set_ext(18'h3f);
    expect_rd(ad(BPABC_IDX_A_DATA), 8'h3f);
    put(BPABC_IDX_CTRL, 8'h01);
    expect_rd(ad(BPABC_IDX_A_DATA), 8'h3b);
  endtask : t_port_a
  task automatic t_osc;
    logic act;
    for (int o = 0; o < 4; o++) begin
      put(BPABC_IDX_CTRL, 8'(o << 1));
      put(BPABC_IDX_A_PUE, 8'h90);
      act = (o == int'(BPABC_OPT_INTERNAL)) || (o == int'(BPABC_OPT_RC));
      chk(32'(clk_act), 32'(act));
      chk(32'(a_pu), {27'h0, !act, 4'h0});
      chk(32'(a_oe_n[4]), 32'(!act));
    end
    put(BPABC_IDX_CTRL, 8'h00);
    put(BPABC_IDX_A_PUE, 8'h10);
    chk(32'(clk_act), 32'h0);
    chk(32'(a_pu), 32'h10);
  endtask : t_osc
  task automatic t_port_c;
    set_ext({4'ha, 14'h0});
    put(BPABC_IDX_C_DATA, 8'h05);
    expect_rd(ad(BPABC_IDX_C_DATA), 8'h0a);
    put(BPABC_IDX_C_DIR, 8'h07);
    chk(32'({c_oe_n, c_out}), 32'h05);
    expect_rd(ad(BPABC_IDX_C_DATA), 8'h0d);
    expect_rd(ad(BPABC_IDX_C_DIR), 8'h07);
    @(posedge clk);
    be <= 4'h0;
    put(BPABC_IDX_C_DIR, 8'h00);
    @(posedge clk);
    be <= 4'h1;
    expect_rd(ad(BPABC_IDX_C_DIR), 8'h07);
    bus(1'b1, 6'h3c, 8'hff);
    expect_rd(6'h3c, 8'h00);
  endtask : t_port_c
  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_port_b;
    t_pullup;
    t_port_a;
    t_osc;
    t_port_c;
    tally_and_finish;
  end
endmodule : bidir_port_abc_pins_tb_top
`default_nettype wire
